/* File: inc/mmes_defines.svh */
// Purpose: Constants of the mesh memory event selector
// Assumes: Included by the package only
// Notes:   Byte offsets on the register bus; timing has no long counts
`ifndef MMES_DEFINES_SVH
`define MMES_DEFINES_SVH
// ==========================================================================
// Geometry
`define MMES_NUM_CTR      5
`define MMES_NUM_RESTR    4
`define MMES_XQ_W         26
// ==========================================================================
// Event codes
`define MMES_CODE_MEMCTL_WRITE      8'h25
`define MMES_CODE_ERROR_LINE        8'hE6
`define MMES_CODE_TABLE_RESET       8'h57
`define MMES_CODE_DEMAND_DROP       8'h58
`define MMES_CODE_DROP_REASON_CH0   8'h59
`define MMES_CODE_DROP_REASON_CH1   8'h5A
`define MMES_CODE_INGRESS_DEALLOC   8'h62
`define MMES_CODE_HORZ_BOUNCE       8'hAC
`define MMES_CODE_VERT_BOUNCE       8'hAA
// ==========================================================================
// Register map: region in address bits 7:5, counter index in bits 4:2
`define MMES_REGION_CTL   3'h0
`define MMES_REGION_XQ    3'h1
`define MMES_REGION_CNT   3'h2
`define MMES_CTL_BASE     8'h00
`define MMES_XQ_BASE      8'h20
`define MMES_CNT_BASE     8'h40
`define MMES_CTL_EN_BIT   22
`define MMES_CTL_RESET    17'h00000
`define MMES_XQ_RESET     26'h0000000
`define MMES_CNT_RESET    32'h00000000
// ==========================================================================
// Qualifier field bits (bit 0 of the field is bit 32 of the selector)
`define MMES_XQ_TRANSGRESS  0
`define MMES_XQ_NONINCL     1
`define MMES_XQ_NONINCL_MISS 2
`define MMES_XQ_CH0         3
`define MMES_XQ_CH1         4
`endif

/* File: inc/mmes_pkg.sv */
// Purpose: Types of the mesh memory event selector
// Assumes: mmes_defines.svh on the include path
// Notes:   Event bit order follows the unit-mask bit order
package mmes_pkg;
`include "mmes_defines.svh"
   // ========================================================================
   // Event carriers
   typedef struct packed {
      logic persistent;
      logic ddr_cache;
      logic ddr_mem;
      logic partial_isoch;
      logic full_isoch;
      logic partial;
      logic full;
      logic non_inclusive_miss;
      logic non_inclusive;
      logic transgress;
   } mmes_wr_t;
   typedef struct packed {
      mmes_wr_t [1:0]        memctl_write_event;
      logic [1:0][5:0]       prefetch_table_reset_event;
      logic [3:0]            demand_prefetch_drop_event;
      logic [10:0]           prefetch_drop_reason_ch0_event;
      logic [10:0]           prefetch_drop_reason_ch1_event;
      logic [3:0]            prefetch_ingress_dealloc_event;
      logic [3:0]            horizontal_bounce_event;
      logic [4:0]            vertical_bounce_event;
   } mmes_ev_t;
   // ========================================================================
   // Bus and state
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } mmes_avs_req_t;
   typedef struct packed {
      logic       en;
      logic [7:0] umask;
      logic [7:0] code;
   } mmes_ctl_t;
   typedef struct packed {
      mmes_ctl_t [`MMES_NUM_CTR-1:0]                ctl;
      logic [`MMES_NUM_CTR-1:0][`MMES_XQ_W-1:0]     xq;
      logic [`MMES_NUM_CTR-1:0][31:0]               cnt;
      logic [1:0]                                   err_meta;
      logic [1:0]                                   err_sync;
      logic                                         ack;
      logic [31:0]                                  rdata;
   } mmes_state_t;
endpackage : mmes_pkg

/* File: verilog/mmes_event_select.sv */
// Purpose: Event selection, qualification and counting for the
//          mesh-to-memory agent performance counters
// Assumes: One 50 MHz clock; event pulses are synchronous except the
//          multi-bit error lines, which arrive from another block
// Notes:   Avalon-MM slave, one wait state per access
//
// Overview of operation
// - Code 25 counts writes, counters 0-3
// - Umask bit 8 counts full non-isoch writes
// - Umask bit 11 counts isochronous partial writes
// - Umask bit 14 counts DRAM-as-cache writes
// - Umask bit 15 counts persistent module writes
// - Zero umask, qualifier bit 0: transgress writes
// - Zero umask, qualifier bit 2: non-inclusive misses
// - Code E6 counts error line high cycles
// - Code 57 umask bit 10: miss resets
// - Umask bit 12 counts credit-pending resets
// - Code 58 counts demand drops per source
// - Codes 59/5A, umask bit 14: CAM full
// - Umask bit 8 counts secure-region drops
// - Umask bit 11 counts back-to-back drops
// - Code 62 umask bit 8: squashed deallocs
// - Umask bit 9 counts posted one-level deallocs
// - Code AC counts horizontal bounce cycles
// - Code AA counts vertical bounce cycles
module mmes_event_select
   import mmes_pkg::*;
(
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset,
   // Register bus
   input  wire mmes_pkg::mmes_avs_req_t avs_req,
   output logic                     avs_waitrequest,
   output logic [31:0]              avs_readdata,
   // Event sources
   input  wire mmes_pkg::mmes_ev_t  events,
   input  wire logic [1:0]          multi_bit_error_line
);
   import mmes_pkg::*;

   // ========================================================================
   // Functions
   function automatic logic is_restricted(logic [7:0] code);
      return (code == `MMES_CODE_MEMCTL_WRITE) || (code == `MMES_CODE_TABLE_RESET) ||
             (code == `MMES_CODE_DEMAND_DROP) || (code == `MMES_CODE_DROP_REASON_CH0) ||
             (code == `MMES_CODE_DROP_REASON_CH1) ||
             (code == `MMES_CODE_INGRESS_DEALLOC);
   endfunction : is_restricted

   function automatic logic ev_hit(mmes_ctl_t c, logic [`MMES_XQ_W-1:0] x,
                                   mmes_ev_t ev, logic [1:0] err);
      logic     h;
      logic     any_wr;
      mmes_wr_t w;
      h = 1'b0;
      case (c.code)
         `MMES_CODE_MEMCTL_WRITE:
         begin
            for (int ch = 0; ch < 2; ch++)
            begin
               w = ev.memctl_write_event[ch];
               any_wr = w.full | w.partial | w.full_isoch | w.partial_isoch;
               if (x[`MMES_XQ_CH0 + ch])
               begin
                  if (c.umask == 8'h00)
                     h = h | (x[`MMES_XQ_TRANSGRESS] & w.transgress)
                           | (x[`MMES_XQ_NONINCL] & w.non_inclusive)
                           | (x[`MMES_XQ_NONINCL_MISS] & w.non_inclusive_miss);
                  else
                     h = h | (|(c.umask & {w.persistent, w.ddr_cache, w.ddr_mem, any_wr,
                                           w.partial_isoch, w.full_isoch, w.partial,
                                           w.full}));
               end
            end
         end
         `MMES_CODE_ERROR_LINE:
            h = |(c.umask[1:0] & err);
         `MMES_CODE_TABLE_RESET:
         begin
            for (int ch = 0; ch < 2; ch++)
               h = h | (x[ch] & (|(c.umask[5:0] &
                                   ev.prefetch_table_reset_event[ch])));
         end
         `MMES_CODE_DEMAND_DROP:
            h = |(c.umask[3:0] & ev.demand_prefetch_drop_event);
         `MMES_CODE_DROP_REASON_CH0:
            h = (|(c.umask & ev.prefetch_drop_reason_ch0_event[7:0])) |
                (|(x[2:0] & ev.prefetch_drop_reason_ch0_event[10:8]));
         `MMES_CODE_DROP_REASON_CH1:
            h = (|(c.umask & ev.prefetch_drop_reason_ch1_event[7:0])) |
                (|(x[2:0] & ev.prefetch_drop_reason_ch1_event[10:8]));
         `MMES_CODE_INGRESS_DEALLOC:
            h = |(c.umask[3:0] & ev.prefetch_ingress_dealloc_event);
         `MMES_CODE_HORZ_BOUNCE:
            h = |(c.umask[3:0] & ev.horizontal_bounce_event);
         `MMES_CODE_VERT_BOUNCE:
            h = |(c.umask[4:0] & ev.vertical_bounce_event);
         default:
            h = 1'b0;
      endcase
      return h;
   endfunction : ev_hit

   function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw,
                                            logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (be[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction : be_merge

   // ========================================================================
   // State
   mmes_state_t q_ff;
   mmes_state_t nxt_q;

   logic [2:0]                  region;
   logic [2:0]                  idx;
   logic                        idx_ok;
   logic                        bus_req;
   logic                        wr_take;
   logic [`MMES_NUM_CTR-1:0]    cnt_wr;
   logic [`MMES_NUM_CTR-1:0]    hit;

   assign region  = avs_req.address[7:5];
   assign idx     = avs_req.address[4:2];
   // Unaligned or out-of-range indices fall outside the map
   assign idx_ok  = (avs_req.address[1:0] == 2'b00) && (idx < 3'(`MMES_NUM_CTR));
   assign bus_req = avs_req.read | avs_req.write;
   // First cycle of every access is a wait state, so read data is already
   // registered when waitrequest falls
   assign avs_waitrequest = bus_req & ~q_ff.ack;
   assign wr_take         = avs_req.write & q_ff.ack;
   assign avs_readdata    = q_ff.rdata;

   always_comb
   begin
      for (int i = 0; i < `MMES_NUM_CTR; i++)
      begin
         cnt_wr[i] = wr_take && idx_ok && (region == `MMES_REGION_CNT) &&
                     (idx == 3'(i));
         hit[i]    = q_ff.ctl[i].en &&
                     ev_hit(q_ff.ctl[i], q_ff.xq[i], events, q_ff.err_sync) &&
                     (!is_restricted(q_ff.ctl[i].code) ||
                      (i < `MMES_NUM_RESTR));
      end
   end

   // ========================================================================
   // Next state
   always_comb
   begin
      logic [31:0] ctl_word;
      ctl_word = 32'h00000000;
      nxt_q = q_ff;
      // Error lines come from another block: two flops before use
      nxt_q.err_meta = multi_bit_error_line;
      nxt_q.err_sync = q_ff.err_meta;
      nxt_q.ack      = bus_req & ~q_ff.ack;
      if (avs_req.read && !q_ff.ack)
      begin
         nxt_q.rdata = 32'h00000000;
         if (idx_ok)
         begin
            case (region)
               `MMES_REGION_CTL:
                  nxt_q.rdata = {9'h000, q_ff.ctl[idx].en, 6'h00,
                                 q_ff.ctl[idx].umask, q_ff.ctl[idx].code};
               `MMES_REGION_XQ:
                  nxt_q.rdata = {6'h00, q_ff.xq[idx]};
               `MMES_REGION_CNT:
                  nxt_q.rdata = q_ff.cnt[idx];
               default:
                  nxt_q.rdata = 32'h00000000;
            endcase
         end
      end
      if (wr_take && idx_ok)
      begin
         case (region)
            `MMES_REGION_CTL:
            begin
               ctl_word = be_merge({9'h000, q_ff.ctl[idx].en, 6'h00,
                                    q_ff.ctl[idx].umask, q_ff.ctl[idx].code},
                                   avs_req.writedata, avs_req.byteenable);
               nxt_q.ctl[idx] = {ctl_word[`MMES_CTL_EN_BIT], ctl_word[15:0]};
            end
            `MMES_REGION_XQ:
            begin
               ctl_word = be_merge({6'h00, q_ff.xq[idx]}, avs_req.writedata,
                                   avs_req.byteenable);
               nxt_q.xq[idx] = ctl_word[`MMES_XQ_W-1:0];
            end
            default:
               ctl_word = 32'h00000000;
         endcase
      end
      for (int i = 0; i < `MMES_NUM_CTR; i++)
      begin
         // A software preset replaces the value; the event of that cycle is
         // dropped, a trade against a second adder
         if (cnt_wr[i])
            nxt_q.cnt[i] = be_merge(q_ff.cnt[i], avs_req.writedata, avs_req.byteenable);
         else if (hit[i])
            nxt_q.cnt[i] = q_ff.cnt[i] + 32'h00000001;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         q_ff <= '0;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   // ========================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // A let, unlike a function body, has every signal that it names sampled
   // together with the rest of the property
   let cfg0(code, um, x) = q_ff.ctl[0].en && (q_ff.ctl[0].code == code) &&
      (q_ff.ctl[0].umask == um) && (q_ff.xq[0][4:0] == x) && !cnt_wr[0];

   sequence s_bump0;
      ##1 (q_ff.cnt[0] == $past(q_ff.cnt[0]) + 32'h00000001);
   endsequence

   sequence s_hold0;
      ##1 $stable(q_ff.cnt[0]);
   endsequence

   a_bus_answer: assert property (bus_req |-> ##[0:1] !avs_waitrequest)
      else $error("bus access not answered within one wait state");
   a_write_full: assert property (
      cfg0(8'h25, 8'h01, 5'b11000) && events.memctl_write_event[1].full |-> s_bump0)
      else $error("full write not counted");
   a_write_isoch: assert property (
      cfg0(8'h25, 8'h08, 5'b01000) && events.memctl_write_event[0].partial_isoch
      |-> s_bump0)
      else $error("isoch partial write not counted");
   a_write_any: assert property (
      cfg0(8'h25, 8'h10, 5'b10000) && events.memctl_write_event[1].partial |-> s_bump0)
      else $error("write of any kind not counted");
   a_write_cache: assert property (
      cfg0(8'h25, 8'h40, 5'b01000) && events.memctl_write_event[0].ddr_cache
      |-> s_bump0)
      else $error("cache write not counted");
   a_write_pmem: assert property (
      cfg0(8'h25, 8'h80, 5'b10000) && events.memctl_write_event[1].persistent
      |-> s_bump0)
      else $error("persistent write not counted");
   a_write_trans: assert property (
      cfg0(8'h25, 8'h00, 5'b11001) && events.memctl_write_event[0].transgress
      |-> s_bump0)
      else $error("transgress write not counted");
   a_write_miss: assert property (
      cfg0(8'h25, 8'h00, 5'b11100) && !events.memctl_write_event[0].non_inclusive_miss
      && !events.memctl_write_event[1].non_inclusive_miss |-> s_hold0)
      else $error("counted without a non-inclusive miss");
   a_err_sync: assert property (
      (multi_bit_error_line == 2'b01) [*2] |=> (q_ff.err_sync == 2'b01))
      else $error("error line not seen after two flops");
   a_err_count: assert property (
      cfg0(8'hE6, 8'h01, q_ff.xq[0][4:0]) && q_ff.err_sync[0] |-> s_bump0)
      else $error("error line cycle not counted");
   a_err_quiet: assert property (
      cfg0(8'hE6, 8'h01, q_ff.xq[0][4:0]) && !q_ff.err_sync[0] |-> s_hold0)
      else $error("error count without a synchronised error line");
   a_reset_miss: assert property (
      cfg0(8'h57, 8'h04, {q_ff.xq[0][4:2], 2'b01}) &&
      events.prefetch_table_reset_event[0][2] |-> s_bump0)
      else $error("miss reset not counted");
   a_reset_credit: assert property (
      cfg0(8'h57, 8'h10, {q_ff.xq[0][4:2], 2'b10}) &&
      events.prefetch_table_reset_event[1][4] |-> s_bump0)
      else $error("credit reset not counted");
   a_demand_local: assert property (
      cfg0(8'h58, 8'h05, q_ff.xq[0][4:0]) &&
      (events.demand_prefetch_drop_event[3:0] == 4'hA) |-> s_hold0)
      else $error("link drops counted under local selection");
   a_drop_full: assert property (
      cfg0(8'h5A, 8'h40, 5'b00000) && events.prefetch_drop_reason_ch1_event[6]
      |-> s_bump0)
      else $error("cam full drop not counted");
   a_drop_secure: assert property (
      cfg0(8'h59, 8'h01, 5'b00000) && events.prefetch_drop_reason_ch0_event[0]
      |-> s_bump0)
      else $error("secure drop not counted");
   a_drop_b2b: assert property (
      cfg0(8'h59, 8'h08, 5'b00000) && events.prefetch_drop_reason_ch0_event[3]
      |-> s_bump0)
      else $error("back-to-back drop not counted");
   a_ingress_squash: assert property (
      cfg0(8'h62, 8'h01, q_ff.xq[0][4:0]) && events.prefetch_ingress_dealloc_event[0]
      |-> s_bump0)
      else $error("squash dealloc not counted");
   a_ingress_posted: assert property (
      cfg0(8'h62, 8'h02, q_ff.xq[0][4:0]) && events.prefetch_ingress_dealloc_event[1]
      |-> s_bump0)
      else $error("posted dealloc not counted");
   a_horz_bounce: assert property (
      cfg0(8'hAC, 8'h0F, q_ff.xq[0][4:0]) && (events.horizontal_bounce_event == 4'h0)
      |-> s_hold0)
      else $error("horizontal count without bounce");
   a_vert_bounce: assert property (
      cfg0(8'hAA, 8'h10, q_ff.xq[0][4:0]) && events.vertical_bounce_event[4]
      |-> s_bump0)
      else $error("vertical bounce not counted");
   a_or_once: assert property (
      cfg0(8'h25, 8'h11, 5'b11000) && events.memctl_write_event[0].full &&
      events.memctl_write_event[1].full |-> s_bump0)
      else $error("several sub-events did not add exactly one");
   a_restr_ctr4: assert property (
      q_ff.ctl[4].en && is_restricted(q_ff.ctl[4].code) && !cnt_wr[4]
      |=> $stable(q_ff.cnt[4]))
      else $error("restricted event counted on counter 4");
   a_write_ctr4: assert property (
      q_ff.ctl[4].code == `MMES_CODE_MEMCTL_WRITE |-> !hit[4])
      else $error("write event accepted above counter 3");

   // Bus answers and counter 0 housekeeping
   a_ack_pulse: assert property (
      q_ff.ack |=> !q_ff.ack)
      else $error("acknowledge stood for two cycles");
   a_read_unmapped: assert property (
      avs_req.read && !q_ff.ack && !idx_ok |=> (avs_readdata == 32'h00000000))
      else $error("unmapped read returned data");
   a_rdata_hold: assert property (
      !(avs_req.read && !q_ff.ack) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   a_ctr_off: assert property (
      !q_ff.ctl[0].en && !cnt_wr[0] |=> $stable(q_ff.cnt[0]))
      else $error("disabled counter moved");
   a_preset_wins: assert property (
      cnt_wr[0] && (avs_req.byteenable == 4'hF)
      |=> (q_ff.cnt[0] == $past(avs_req.writedata)))
      else $error("counter preset not taken");
endmodule : mmes_event_select

/* File: sim/mmes_event_source.sv */
// Purpose: Far-side model: memory path, prefetch table and ring stop pulses
// Assumes: Bench supplies the pattern; events share the selector clock
// Notes:   Error lines move on the falling edge, unrelated to sampling
module mmes_event_source
   import mmes_pkg::*;
(
   // Clock
   input  wire logic                ref_clk,
   // Bench stimulus
   input  wire logic                ev_on,
   input  wire mmes_pkg::mmes_ev_t  ev_pattern,
   input  wire logic [1:0]          err_hold,
   // Toward the selector
   output mmes_pkg::mmes_ev_t       events,
   output logic [1:0]               multi_bit_error_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pulses last one cycle and are quiet outside a burst
   assign events = ev_on ? ev_pattern : '0;
   // Error lines come from another block, so they never move on the sampling edge
   always @(negedge ref_clk)
      multi_bit_error_line <= err_hold;
endmodule : mmes_event_source

/* File: sim/tb_mmes_event_select.sv */
// Purpose: Self-checking bench of the mesh memory event selector
// Assumes: mmes_pkg compiled first; one 50 MHz clock
// Notes:   Selections drawn from a fixed-seed shift register
module tb_mmes_event_select;
   timeunit 1ns;
   timeprecision 1ps;
   import mmes_pkg::*;
   // ========================================================================
   // Signals
   logic          ref_clk      = 1'b0;
   logic          reset        = 1'b1;
   mmes_avs_req_t req          = '0;
   logic          avs_waitrequest;
   logic [31:0]   avs_readdata;
   logic          ev_on        = 1'b0;
   mmes_ev_t      ev_pattern   = '0;
   logic [1:0]    err_hold     = 2'b00;
   mmes_ev_t      events;
   logic [1:0]    err_line;
   logic [31:0]   seed         = 32'h16E1D87D;
   logic [31:0]   exp_cnt      = 32'h0;
   logic [2:0]    cur_n        = 3'h0;
   logic          cur_en       = 1'b0;
   logic [7:0]    cur_code     = 8'h00;
   logic [7:0]    cur_umask    = 8'h00;
   logic [25:0]   cur_xq       = 26'h0;
   logic [7:0]    codes [10]   = '{8'h25, 8'hE6, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h62,
                                   8'hAC, 8'hAA, 8'h00};
   int            n_errors     = 0;
   int            total_checks = 0;
   always #10 ref_clk = ~ref_clk;
   mmes_event_select i_mmes_event_select (
      .ref_clk(ref_clk), .reset(reset), .avs_req(req),
      .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
      .events(events), .multi_bit_error_line(err_line));
   mmes_event_source i_mmes_event_source (
      .ref_clk(ref_clk), .ev_on(ev_on), .ev_pattern(ev_pattern), .err_hold(err_hold),
      .events(events), .multi_bit_error_line(err_line));
   // ========================================================================
   // Prediction
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 32; i++)
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic logic hit(logic [2:0] n, logic en, logic [7:0] c, logic [7:0] u,
                                logic [25:0] q, mmes_ev_t e);
      logic [9:0] w;
      logic       h;
      h = 1'b0;
      if (!en || (n == 3'd4 && c inside {8'h25, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h62}))
         return 1'b0;
      for (int ch = 0; ch < 2; ch++)
      begin
         w = e.memctl_write_event[ch];
         if (c == 8'h25 && q[3 + ch])
            h |= (u == 8'h00) ? |(w[2:0] & q[2:0])
               : |({u[7:5], u[3:0]} & {w[9:7], w[6:3]}) | (u[4] & |w[6:3]);
         if (c == 8'h57 && q[ch])
            h |= |(u[5:0] & e.prefetch_table_reset_event[ch]);
      end
      case (c)
         8'h58:   h = |(u[3:0] & e.demand_prefetch_drop_event);
         8'h59:   h = |({q[2:0], u} & e.prefetch_drop_reason_ch0_event);
         8'h5A:   h = |({q[2:0], u} & e.prefetch_drop_reason_ch1_event);
         8'h62:   h = |(u[3:0] & e.prefetch_ingress_dealloc_event);
         8'hAC:   h = |(u[3:0] & e.horizontal_bounce_event);
         8'hAA:   h = |(u[4:0] & e.vertical_bounce_event);
         default: ;
      endcase
      return h;
   endfunction : hit
   // Events are zero outside bursts, so only burst cycles move this
   always @(posedge ref_clk)
      exp_cnt <= exp_cnt + {31'h0, hit(cur_n, cur_en, cur_code, cur_umask, cur_xq, events)};
   // ========================================================================
   // Bus and checks
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      logic w;
      int   t;
      t = 0;
      req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
      // Read just after the edge, outputs still show what that edge sampled
      do
      begin
         @(posedge ref_clk);
         w = avs_waitrequest;
         t++;
      end
      while (w !== 1'b0 && t < 40);
      q = avs_readdata;
      if (t >= 40)
         n_errors++;
      req.read  <= 1'b0;
      req.write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic trial(input logic [2:0] n, input logic en, input logic [7:0] c,
                        input logic [7:0] u, input logic [25:0] q, input int len);
      logic [31:0] s;
      logic [31:0] x;
      logic [95:0] p;
      cur_n     <= n;
      cur_en    <= en;
      cur_code  <= c;
      cur_umask <= u;
      cur_xq    <= q;
      bus(1'b1, {3'h0, n, 2'h0}, {9'h0, en, 6'h0, u, c}, x);
      bus(1'b1, {3'h1, n, 2'h0}, {6'h0, q}, x);
      bus(1'b1, {3'h2, n, 2'h0}, 32'h0, x);
      s = exp_cnt;
      if (c == 8'hE6)
      begin
         err_hold <= 2'b11;
         repeat (3) @(posedge ref_clk);
         err_hold <= 2'b01;
         repeat (2) @(posedge ref_clk);
         err_hold <= 2'b00;
         repeat (6) @(posedge ref_clk);
      end
      else
         repeat (len)
         begin
            p = {rnd(), rnd(), rnd()} & {rnd(), rnd(), rnd()};
            ev_on      <= 1'b1;
            ev_pattern <= p[$bits(mmes_ev_t)-1:0];
            @(posedge ref_clk);
         end
      ev_on <= 1'b0;
      @(posedge ref_clk);
      bus(1'b0, {3'h2, n, 2'h0}, 32'h0, x);
      chk(x, (c != 8'hE6) ? exp_cnt - s : (en && u[0]) ? 32'd5 : (en && u[1]) ? 32'd3 : 32'd0);
   endtask : trial
   task automatic end_sim();
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // ========================================================================
   // Sequence
   initial
   begin
      logic [31:0] x;
      logic [31:0] r;
      logic [7:0]  wa [5] = '{8'h04, 8'h24, 8'h44, 8'h80, 8'h41};
      logic [31:0] we [5] = '{32'h0040FFFF, 32'h03FFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0};
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      // Every word reads zero after reset, unmapped ones included
      for (int a = 0; a < 256; a += 4)
      begin
         bus(1'b0, 8'(a), 32'h0, x);
         chk(x, 32'h0);
      end
      // Reserved bits read zero; unmapped and unaligned writes are dropped
      foreach (wa[i])
      begin
         bus(1'b1, wa[i], 32'hFFFFFFFF, x);
         bus(1'b0, wa[i], 32'h0, x);
         chk(x, we[i]);
      end
      trial(3'd4, 1'b1, 8'h25, 8'h10, 26'h18, 12);
      trial(3'd3, 1'b1, 8'h25, 8'h00, 26'h19, 12);
      trial(3'd2, 1'b1, 8'h25, 8'h00, 26'h1C, 12);
      trial(3'd1, 1'b1, 8'h58, 8'h05, 26'h00, 12);
      trial(3'd0, 1'b1, 8'h58, 8'h0A, 26'h00, 12);
      trial(3'd4, 1'b1, 8'hAA, 8'h1F, 26'h00, 12);
      for (int k = 0; k < 4; k++)
         trial(3'(k ^ 1), 1'b1, 8'hE6, 8'(k), 26'h0, 0);
      repeat (80)
      begin
         r = rnd();
         trial(3'(r[7:0] % 5), r[10:8] != 3'h0, codes[r[15:12] % 10], r[23:16],
               {21'h0, r[28:24]}, 12);
      end
      end_sim();
   end
   initial
   begin
      #(20 * 40000);
      n_errors++;
      end_sim();
   end
endmodule : tb_mmes_event_select
